/* File: shared/rtc_cal_pkg.sv */
// Constants, field layouts and carrier types for the calendar time registers
package rtc_cal_pkg;

    // ****************************************************************
    // Register offsets and field indices
    // ****************************************************************
    localparam int NUM_FIELDS = 6;
    localparam int IDX_SECONDS = 0;
    localparam int IDX_MINUTES = 1;
    localparam int IDX_HOURS = 2;
    localparam int IDX_DAY = 3;
    localparam int IDX_MONTH = 4;
    localparam int IDX_YEAR = 5;

    localparam logic [7:0] OFF_SECONDS = 8'h00;
    localparam logic [7:0] OFF_MINUTES = 8'h01;
    localparam logic [7:0] OFF_HOURS = 8'h02;
    localparam logic [7:0] OFF_DAY = 8'h03;
    localparam logic [7:0] OFF_MONTH = 8'h04;
    localparam logic [7:0] OFF_YEAR = 8'h05;
    localparam logic [7:0] FIELD_OFFSET [NUM_FIELDS] =
        '{OFF_SECONDS, OFF_MINUTES, OFF_HOURS, OFF_DAY, OFF_MONTH, OFF_YEAR};

    // ****************************************************************
    // Field layouts: writable bits per register
    // ****************************************************************
    localparam logic [7:0] MASK_SECONDS = 8'h7f;
    localparam logic [7:0] MASK_MINUTES = 8'h7f;
    localparam logic [7:0] MASK_HOURS = 8'h3f;
    localparam logic [7:0] MASK_DAY = 8'h3f;
    localparam logic [7:0] MASK_MONTH = 8'h1f;
    localparam logic [7:0] MASK_YEAR = 8'hff;
    localparam logic [7:0] FIELD_MASK [NUM_FIELDS] =
        '{MASK_SECONDS, MASK_MINUTES, MASK_HOURS, MASK_DAY, MASK_MONTH, MASK_YEAR};
    localparam logic [7:0] MASK_HOURS_READ = 8'hbf;
    localparam int AFTERNOON_FLAG_POS = 7;

    // ****************************************************************
    // Values after reset
    // ****************************************************************
    localparam logic [7:0] RST_SECONDS = 8'h00;
    localparam logic [7:0] RST_MINUTES = 8'h00;
    localparam logic [7:0] RST_HOURS = 8'h00;
    localparam logic [7:0] RST_DAY = 8'h01;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_YEAR = 8'h00;
    localparam logic [7:0] FIELD_RESET [NUM_FIELDS] =
        '{RST_SECONDS, RST_MINUTES, RST_HOURS, RST_DAY, RST_MONTH, RST_YEAR};

    // ****************************************************************
    // Counting ranges in BCD
    // ****************************************************************
    localparam logic [7:0] MAX_SECONDS = 8'h59;
    localparam logic [7:0] MAX_MINUTES = 8'h59;
    localparam logic [7:0] MAX_HOURS = 8'h23;
    localparam logic [7:0] MAX_MONTH = 8'h12;
    localparam logic [7:0] MAX_YEAR = 8'h99;
    localparam logic [7:0] DAYS_28 = 8'h28;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_31 = 8'h31;
    localparam logic [7:0] FIELD_MIN [NUM_FIELDS] =
        '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
    localparam logic [3:0] BCD_UNITS_MAX = 4'h9;

    // Binary month numbers with short lengths, and hours per half day
    localparam logic [6:0] MONTH_FEB = 7'h02;
    localparam logic [6:0] MONTH_APR = 7'h04;
    localparam logic [6:0] MONTH_JUN = 7'h06;
    localparam logic [6:0] MONTH_SEP = 7'h09;
    localparam logic [6:0] MONTH_NOV = 7'h0b;
    localparam logic [6:0] HOURS_PER_HALF = 7'h0c;

    // ****************************************************************
    // Register port carrier
    // ****************************************************************
    typedef struct packed {
        logic [7:0] addr;
        logic wr_en;
        logic rd_en;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

/* File: verilog/bcd_field_step.sv */
// One two-digit BCD calendar field advanced by one with wrap to its minimum
`timescale 1ns/100ps
module bcd_field_step (
    input wire logic [7:0] value_in,
    input wire logic [7:0] min_in,
    input wire logic [7:0] max_in,
    input wire logic step_in,
    output logic [7:0] value_out,
    output logic wrap_out
);

    // ****************************************************************
    // Increment
    // ****************************************************************
    // BCD order equals numeric order, so a plain compare finds the top
    wire at_max = value_in >= max_in;
    wire units_full = value_in[3:0] >= rtc_cal_pkg::BCD_UNITS_MAX;
    wire [3:0] tens_inc = value_in[7:4] + 4'h1;
    wire [3:0] units_inc = value_in[3:0] + 4'h1;
    wire [7:0] bumped = units_full ? {tens_inc, 4'h0} : {value_in[7:4], units_inc};
    wire [7:0] advanced = at_max ? min_in : bumped;

    assign value_out = step_in ? advanced : value_in;
    assign wrap_out = step_in && at_max;

endmodule

/* File: verilog/rtc_calendar_time_registers.sv */
// Calendar time registers: BCD time and date, counting, host access
`timescale 1ns/100ps

// Summary of operation
// - Seconds: tens bits 6-4 0-5, units 0-9
// - Minutes: tens bits 6-4 0-5, units 0-9
// - Hours: tens bits 5-4 0-2, units 0-9
// - Bit 7 afternoon in 12h, else zero
// - Day: tens bits 5-4 0-3, units 0-9
// - Month: tens bit 4, units bits 3-0
// - Months 01 to 12, January after reset
// - Day resets to the first
// - Mode bit picks 24h or 12h, undisturbed
// - Year two BCD digits, reset to zero
module rtc_calendar_time_registers (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire rtc_cal_pkg::reg_req_t req_in,
    input wire logic second_tick_in,
    input wire logic rtc_running_in,
    input wire logic mode_12h_in,
    output logic [7:0] rd_data_out,
    output logic rd_valid_out
);

    // ****************************************************************
    // Conversions
    // ****************************************************************
    function automatic logic [6:0] bcd2bin(input logic [7:0] bcd);
        logic [6:0] tens;
        logic [6:0] units;
        tens = {3'h0, bcd[7:4]};
        units = {3'h0, bcd[3:0]};
        bcd2bin = 7'((tens * 7'd10) + units);
    endfunction

    function automatic logic [7:0] bin2bcd(input logic [6:0] bin);
        logic [6:0] tens;
        logic [6:0] units;
        tens = bin / 7'd10;
        units = bin % 7'd10;
        bin2bcd = {tens[3:0], units[3:0]};
    endfunction

    // ****************************************************************
    // Storage and step chain
    // ****************************************************************
    logic [7:0] cal_r [rtc_cal_pkg::NUM_FIELDS];
    logic [7:0] cal_nxt [rtc_cal_pkg::NUM_FIELDS];
    logic [7:0] stepped [rtc_cal_pkg::NUM_FIELDS];
    logic [7:0] wr_value [rtc_cal_pkg::NUM_FIELDS];
    logic [7:0] field_max [rtc_cal_pkg::NUM_FIELDS];
    logic [rtc_cal_pkg::NUM_FIELDS-1:0] step_en;
    logic [rtc_cal_pkg::NUM_FIELDS-1:0] wrap;
    logic [rtc_cal_pkg::NUM_FIELDS-1:0] wr_hit;
    logic [7:0] rd_data_r;
    logic [7:0] rd_data_nxt;
    logic rd_valid_r;

    // ****************************************************************
    // Month length
    // ****************************************************************
    wire [6:0] month_bin = bcd2bin(cal_r[rtc_cal_pkg::IDX_MONTH]);
    wire [6:0] year_bin = bcd2bin(cal_r[rtc_cal_pkg::IDX_YEAR]);
    // Two-digit year: every fourth year is leap, 2100 is out of reach
    wire leap_year = (year_bin[1:0] == 2'b00);
    wire short_month = (month_bin == rtc_cal_pkg::MONTH_APR) ||
        (month_bin == rtc_cal_pkg::MONTH_JUN) ||
        (month_bin == rtc_cal_pkg::MONTH_SEP) ||
        (month_bin == rtc_cal_pkg::MONTH_NOV);
    wire is_feb = (month_bin == rtc_cal_pkg::MONTH_FEB);
    wire [7:0] feb_len = leap_year ? rtc_cal_pkg::DAYS_29 : rtc_cal_pkg::DAYS_28;
    wire [7:0] month_len = is_feb ? feb_len :
        (short_month ? rtc_cal_pkg::DAYS_30 : rtc_cal_pkg::DAYS_31);

    assign field_max[rtc_cal_pkg::IDX_SECONDS] = rtc_cal_pkg::MAX_SECONDS;
    assign field_max[rtc_cal_pkg::IDX_MINUTES] = rtc_cal_pkg::MAX_MINUTES;
    assign field_max[rtc_cal_pkg::IDX_HOURS] = rtc_cal_pkg::MAX_HOURS;
    assign field_max[rtc_cal_pkg::IDX_DAY] = month_len;
    assign field_max[rtc_cal_pkg::IDX_MONTH] = rtc_cal_pkg::MAX_MONTH;
    assign field_max[rtc_cal_pkg::IDX_YEAR] = rtc_cal_pkg::MAX_YEAR;

    // ****************************************************************
    // Hours presentation
    // ****************************************************************
    // Hours are kept in 24h form; 12h form exists only at the port,
    // so a mode change never touches the running count
    wire [6:0] h24_bin = bcd2bin(cal_r[rtc_cal_pkg::IDX_HOURS]);
    wire h_is_pm = h24_bin >= rtc_cal_pkg::HOURS_PER_HALF;
    wire [6:0] h_half = h_is_pm ? 7'(h24_bin - rtc_cal_pkg::HOURS_PER_HALF) : h24_bin;
    wire [6:0] h12_bin = (h_half == 7'h00) ? rtc_cal_pkg::HOURS_PER_HALF : h_half;
    wire [7:0] h12_bcd = bin2bcd(h12_bin);
    wire [7:0] hours_rd_12 = {h_is_pm, 1'b0, h12_bcd[5:0]};
    wire [7:0] hours_rd_24 = cal_r[rtc_cal_pkg::IDX_HOURS] & rtc_cal_pkg::MASK_HOURS;
    wire [7:0] hours_rd = mode_12h_in ? hours_rd_12 : hours_rd_24;

    wire [6:0] hw_bin = bcd2bin({2'b00, req_in.wdata[5:0]});
    wire hw_pm = req_in.wdata[rtc_cal_pkg::AFTERNOON_FLAG_POS];
    wire [6:0] hw_base = (hw_bin == rtc_cal_pkg::HOURS_PER_HALF) ? 7'h00 : hw_bin;
    wire [6:0] hw_24 = hw_pm ? 7'(hw_base + rtc_cal_pkg::HOURS_PER_HALF) : hw_base;
    wire [7:0] hw_24_bcd = bin2bcd(hw_24);
    // Afternoon flag is dropped on writes in 24h mode
    wire [7:0] hours_wr = mode_12h_in ? hw_24_bcd :
        (req_in.wdata & rtc_cal_pkg::MASK_HOURS);

    assign step_en[rtc_cal_pkg::IDX_SECONDS] = second_tick_in && rtc_running_in;

    // ****************************************************************
    // Per-field counting and writing
    // ****************************************************************
    for (genvar i = 0; i < rtc_cal_pkg::NUM_FIELDS; i++) begin : g_field
        bcd_field_step u_step (
            .value_in(cal_r[i]),
            .min_in(rtc_cal_pkg::FIELD_MIN[i]),
            .max_in(field_max[i]),
            .step_in(step_en[i]),
            .value_out(stepped[i]),
            .wrap_out(wrap[i])
        );
        if (i > 0) begin : g_carry
            assign step_en[i] = wrap[i-1];
        end
        assign wr_hit[i] = req_in.wr_en && (req_in.addr == rtc_cal_pkg::FIELD_OFFSET[i]);
        if (i == rtc_cal_pkg::IDX_HOURS) begin : g_hours_wr
            assign wr_value[i] = hours_wr;
        end else begin : g_plain_wr
            assign wr_value[i] = req_in.wdata & rtc_cal_pkg::FIELD_MASK[i];
        end
        // A host write beats the count in the same cycle
        assign cal_nxt[i] = wr_hit[i] ? wr_value[i] : stepped[i];
        always_ff @(posedge clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                cal_r[i] <= rtc_cal_pkg::FIELD_RESET[i];
            end else begin
                cal_r[i] <= cal_nxt[i];
            end
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire rd_is_hours = req_in.addr == rtc_cal_pkg::OFF_HOURS;
    wire rd_mapped = req_in.addr <= rtc_cal_pkg::OFF_YEAR;
    wire [2:0] rd_idx = req_in.addr[2:0];
    wire [7:0] rd_plain = rd_mapped ? cal_r[rd_idx] : 8'h00;
    assign rd_data_nxt = !req_in.rd_en ? rd_data_r :
        (rd_is_hours ? hours_rd : rd_plain);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= req_in.rd_en;
        end
    end

    assign rd_data_out = rd_data_r;
    assign rd_valid_out = rd_valid_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic after_reset_r;
    logic rd_hours24_r;
    logic [7:0] rd_rsvd_r;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            after_reset_r <= 1'b0;
            rd_hours24_r <= 1'b0;
            rd_rsvd_r <= 8'h00;
        end else begin
            after_reset_r <= 1'b1;
            rd_hours24_r <= req_in.rd_en && rd_is_hours && !mode_12h_in;
            rd_rsvd_r <= !req_in.rd_en ? 8'h00 :
                (rd_is_hours ? ~rtc_cal_pkg::MASK_HOURS_READ :
                (rd_mapped ? ~rtc_cal_pkg::FIELD_MASK[rd_idx] : 8'hff));
        end
    end

    a_sec_range: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        step_en[0] && !wr_hit[0] |=> cal_r[0][6:4] <= 3'd5 && cal_r[0][3:0] <= 4'h9)
        else $error("seconds left range after a step");

    a_min_carry: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        step_en[1] && !wr_hit[1] && cal_r[1] == 8'h59 |=> cal_r[1] == 8'h00)
        else $error("minutes did not wrap from 59");

    a_hour_wrap: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        step_en[2] && !wr_hit[2] && cal_r[2] == 8'h23 |-> step_en[3] ##1 cal_r[2] == 8'h00)
        else $error("hours did not wrap from 23 into day");

    a_pm_24h_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        rd_hours24_r |-> !rd_data_out[7])
        else $error("afternoon flag set in 24h mode");

    a_day_month_end: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        step_en[3] && !wr_hit[3] && cal_r[3] == 8'h30 && cal_r[4] == 8'h04
        |=> cal_r[3] == 8'h01)
        else $error("day did not wrap after 30 April");

    a_month_wrap: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        step_en[4] && !wr_hit[4] && cal_r[4] == 8'h12 |-> step_en[5] ##1 cal_r[4] == 8'h01)
        else $error("December did not wrap to January");

    a_reset_date: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !after_reset_r |-> cal_r[3] == 8'h01 && cal_r[4] == 8'h01 && cal_r[5] == 8'h00)
        else $error("wrong calendar after reset");

    a_mode_steady: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $changed(mode_12h_in) && !wr_hit[2] && !step_en[2] |=> $stable(cal_r[2]))
        else $error("mode change disturbed hours");

    a_tick_once: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !(second_tick_in && rtc_running_in) && !wr_hit[0] |=> $stable(cal_r[0]))
        else $error("seconds moved without a tick");

    a_rsvd_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        rd_valid_out |-> (rd_data_out & rd_rsvd_r) == 8'h00)
        else $error("reserved bits read nonzero");

    c_minute_carry: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        step_en[1]);
    c_year_roll: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        step_en[5] && cal_r[5] == 8'h99);
    c_leap_day: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        cal_r[3] == 8'h29 && cal_r[4] == 8'h02);
    c_pm_read: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        rd_valid_out && rd_data_out[7]);

endmodule

/* File: test/host_reg_model.sv */
// Host side of the calendar register port: read and write cycles
`timescale 1ns/100ps
module host_reg_model (
    input wire logic clk_in,
    input wire logic [7:0] rd_data_in,
    input wire logic rd_valid_in,
    output rtc_cal_pkg::reg_req_t req_out
);
    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    // Idle address is inverted, and so is data after a write (after a read it carries the address), so a stale value never looks valid
    initial begin
        req_out = '0;
    end

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_in);
        req_out <= '{addr, 1'b1, 1'b0, data};
        @(posedge clk_in);
        req_out <= '{~addr, 1'b0, 1'b0, ~data};
    endtask

    // Answer stands from the taking edge to the next one; taken at that next edge
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data, output logic vld);
        @(posedge clk_in);
        req_out <= '{addr, 1'b0, 1'b1, ~addr};
        @(posedge clk_in);
        req_out <= '{~addr, 1'b0, 1'b0, addr};
        @(posedge clk_in);
        vld = rd_valid_in;
        data = rd_data_in;
    endtask
endmodule

/* File: test/rtc_calendar_time_registers_test.sv */
// Self-checking bench for the calendar time registers
`timescale 1ns/100ps
module rtc_calendar_time_registers_test;
    // ****************************************************************
    // Stimulus and observation
    // ****************************************************************
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic tick = 1'b0;
    logic running = 1'b0;
    logic mode_12h = 1'b0;
    logic [7:0] rd_data;
    logic rd_valid;
    rtc_cal_pkg::reg_req_t req;
    int bad_count = 0;
    int checks_done = 0;
    logic [7:0] hr24 [5] = '{8'h00, 8'h01, 8'h12, 8'h13, 8'h23};
    logic [7:0] hr12 [5] = '{8'h12, 8'h01, 8'h92, 8'h81, 8'h91};
    // Month ends: {year, month, day} before, {month, day} after
    logic [23:0] mend_in [4] = '{24'h01_02_28, 24'h04_02_28, 24'h05_04_30, 24'h05_01_31};
    logic [15:0] mend_out [4] = '{16'h03_01, 16'h02_29, 16'h05_01, 16'h02_01};

    always #5 clk_in = ~clk_in;

    host_reg_model u_host (
        .clk_in(clk_in),
        .rd_data_in(rd_data),
        .rd_valid_in(rd_valid),
        .req_out(req)
    );

    rtc_calendar_time_registers u_dut (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .req_in(req),
        .second_tick_in(tick),
        .rtc_running_in(running),
        .mode_12h_in(mode_12h),
        .rd_data_out(rd_data),
        .rd_valid_out(rd_valid)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        u_host.reg_read(addr, d, v);
        check("read valid", {7'h00, v}, 8'h01);
        check($sformatf("register %h", addr), d, exp);
    endtask

    // Time packed as {year, month, day, hours, minutes, seconds}
    task automatic set_time(input logic [47:0] t);
        for (int i = 0; i < 6; i++) begin
            u_host.reg_write(rtc_cal_pkg::FIELD_OFFSET[i], t[8*i +: 8]);
        end
    endtask

    task automatic chk_time(input logic [47:0] t);
        for (int i = 0; i < 6; i++) begin
            rd_chk(rtc_cal_pkg::FIELD_OFFSET[i], t[8*i +: 8]);
        end
    endtask

    // Tick held high for n edges gives n back-to-back seconds
    task automatic ticks(input int n);
        @(posedge clk_in);
        tick <= 1'b1;
        repeat (n) @(posedge clk_in);
        tick <= 1'b0;
    endtask

    task automatic do_reset();
        reset_n_in <= 1'b0;
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles; this bound is generous
    initial begin
        #200us;
        bad_count++;
        print_verdict();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        do_reset();
        chk_time(48'h00_01_01_00_00_00);
        rd_chk(8'h06, 8'h00);
        $display("test reset values done");

        set_time(48'hff_ff_ff_ff_ff_ff);
        chk_time(48'hff_1f_3f_3f_7f_7f);
        u_host.reg_write(8'h06, 8'h5a);
        rd_chk(8'h06, 8'h00);
        $display("test reserved bits done");

        @(posedge clk_in);
        running <= 1'b1;
        set_time(48'h99_12_31_23_59_59);
        ticks(1);
        chk_time(48'h00_01_01_00_00_00);
        foreach (mend_in[i]) begin
            set_time({mend_in[i], 24'h23_59_59});
            ticks(1);
            rd_chk(8'h03, mend_out[i][7:0]);
            rd_chk(8'h04, mend_out[i][15:8]);
        end
        $display("test carry done");

        set_time(48'h00_01_01_00_00_58);
        ticks(3);
        rd_chk(8'h00, 8'h01);
        rd_chk(8'h01, 8'h01);
        @(posedge clk_in);
        running <= 1'b0;
        ticks(2);
        rd_chk(8'h00, 8'h01);
        $display("test tick stream done");

        foreach (hr24[i]) begin
            @(posedge clk_in);
            mode_12h <= 1'b0;
            u_host.reg_write(8'h02, hr24[i]);
            @(posedge clk_in);
            mode_12h <= 1'b1;
            rd_chk(8'h02, hr12[i]);
            u_host.reg_write(8'h02, hr12[i]);
            @(posedge clk_in);
            mode_12h <= 1'b0;
            rd_chk(8'h02, hr24[i]);
        end
        @(posedge clk_in);
        running <= 1'b1;
        mode_12h <= 1'b1;
        set_time(48'h00_01_01_11_59_59);
        ticks(1);
        rd_chk(8'h02, 8'h92);
        $display("test hour modes done");

        // Mid-run reset must bring back the defaults from a non-default time
        set_time(48'h37_08_15_09_30_45);
        rd_chk(8'h03, 8'h15);
        @(posedge clk_in);
        mode_12h <= 1'b0;
        running <= 1'b0;
        do_reset();
        chk_time(48'h00_01_01_00_00_00);
        $display("test second reset done");
        print_verdict();
    end
endmodule
